// *** hw/axis_id_strap_decode.sv ***
// Purpose: axis address decode from three strap voltages, with
//   ready and fault indicators and the unconfigured led flash
// Assumes: strap voltages are 12-bit millivolt codes sampled on
//   strap_sample; error_event is a one-cycle pulse
// Notes: registers on axi4-lite; one level interrupt
// Contract
// - ready goes high only after power-on initialization completes
// - ready drops whenever an error occurs
// - fault goes high whenever an error condition is detected
// - each strap voltage becomes a code 0..7 by fixed band edges
// - vendor mode address is 64*high - 128 + 8*mid + low
// - canopen address is 64*high + 8*mid + low
// - all straps grounded give address 255 and canopen mode
// - all straps grounded means lss inactive, no assigned node address
// - in lss inactive the green led flashes at one second intervals
`timescale 1ns/100ps
`include "axis_id_params.svh"

module axis_id_strap_decode #(
  parameter int FLASH_CYCLES = (`LED_FLASH_MS * `NS_PER_MS) / `CLK_PERIOD_NS
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // strap voltages
  input wire logic [11:0] strap_low_mv,
  input wire logic [11:0] strap_mid_mv,
  input wire logic [11:0] strap_high_mv,
  input wire logic strap_sample,
  // drive events
  input wire logic init_done,
  input wire logic error_event,
  // indicators
  output logic ready_indicator,
  output logic fault_indicator,
  output logic green_led,
  output logic vendor_can_protocol_mode,
  output logic [8:0] axis_address,
  output logic irq,
  // axi4-lite write address
  input wire logic [4:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [4:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // ==========================================================
  // helpers

  // byte-lane merge of a write into a stored word
  function automatic logic [31:0] lane_merge(input logic [31:0] old_word,
                                             input logic [31:0] new_word,
                                             input logic [3:0] strb);
    logic [31:0] result;
    result = old_word;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        result[i*8 +: 8] = new_word[i*8 +: 8];
      end
    end
    return result;
  endfunction

  // word offset inside the map
  function automatic logic [4:0] word_addr(input logic [4:0] byte_addr);
    return {byte_addr[4:2], 2'h0};
  endfunction

  // ==========================================================
  // declarations
  localparam int FLASH_W = $clog2(FLASH_CYCLES + 1);
  localparam logic [FLASH_W-1:0] FLASH_LAST = FLASH_W'(FLASH_CYCLES - 1);

  axis_id_pkg::drive_state_type state_reg, state_next;
  axis_id_pkg::can_mode_type mode_reg, mode_next;

  logic [2:0] low_value, mid_value, high_value;
  logic [8:0] raw_code;
  logic [8:0] addr_calc;
  logic unstrapped;
  logic sample_take;

  logic [8:0] raw_code_reg;
  logic [8:0] axis_address_reg;
  logic lss_inactive_reg;
  logic addr_valid_reg;
  logic [2:0] control_reg, control_next;
  logic [`IRQ_WIDTH-1:0] irq_status_reg, irq_status_next;
  logic [`IRQ_WIDTH-1:0] irq_mask_reg, irq_mask_next;
  logic [`IRQ_WIDTH-1:0] irq_events;
  logic [`IRQ_WIDTH-1:0] irq_clear;
  logic lss_enter;

  logic [FLASH_W-1:0] flash_count_reg, flash_count_next;
  logic flash_tick;
  logic green_led_reg, green_led_next;

  logic aw_hold_reg, aw_hold_next;
  logic w_hold_reg, w_hold_next;
  logic [4:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic aw_fire, w_fire, aw_have, w_have, do_write;
  logic [4:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_mapped;
  logic wr_control, wr_irq_status, wr_irq_mask;
  logic awready_reg, awready_next;
  logic wready_reg, wready_next;
  logic bvalid_reg, bvalid_next;
  logic [1:0] bresp_reg;

  logic ar_fire;
  logic arready_reg, arready_next;
  logic rvalid_reg, rvalid_next;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  logic [4:0] rd_addr;
  logic rd_mapped;
  logic [31:0] rd_word;
  logic [31:0] status_word;

  logic fault_clear;
  logic ready_reg, fault_reg;

  // ==========================================================
  // strap quantizers
  // band coding
  strap_quantizer u_quant_low (
    .millivolts(strap_low_mv),
    .strap_value(low_value)
  );

  strap_quantizer u_quant_mid (
    .millivolts(strap_mid_mv),
    .strap_value(mid_value)
  );

  strap_quantizer u_quant_high (
    .millivolts(strap_high_mv),
    .strap_value(high_value)
  );

  // ==========================================================
  // address and mode decode
  assign raw_code = {high_value, mid_value, low_value};
  assign unstrapped = raw_code == 9'h000;
  assign mode_next = unstrapped ? axis_id_pkg::MODE_CANOPEN :
    (raw_code[`VENDOR_SEL_BIT] ? axis_id_pkg::MODE_VENDOR : axis_id_pkg::MODE_CANOPEN);
  assign addr_calc = unstrapped ? `UNSTRAPPED_ADDR :
    (mode_next == axis_id_pkg::MODE_VENDOR) ? 9'(raw_code - `VENDOR_ADDR_OFFSET) : raw_code;
  assign sample_take = strap_sample & control_reg[`CTL_DECODE_EN_BIT];
  assign lss_enter = sample_take & unstrapped & ~lss_inactive_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      raw_code_reg <= 9'h000;
      axis_address_reg <= 9'h000;
      mode_reg <= axis_id_pkg::MODE_CANOPEN;
      lss_inactive_reg <= 1'b0;
      addr_valid_reg <= 1'b0;
    end else if (sample_take) begin
      raw_code_reg <= raw_code;
      axis_address_reg <= addr_calc;
      mode_reg <= mode_next;
      lss_inactive_reg <= unstrapped;
      addr_valid_reg <= 1'b1;
    end
  end

  // ==========================================================
  // readiness state machine
  assign fault_clear = do_write & wr_control & wr_strb[0] & wr_data[`CTL_FAULT_CLR_BIT];

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      axis_id_pkg::ST_WAIT_INIT: begin
        if (error_event) begin
          state_next = axis_id_pkg::ST_FAULT;
        end else if (init_done) begin
          state_next = axis_id_pkg::ST_RUN;
        end
      end
      axis_id_pkg::ST_RUN: begin
        if (error_event) begin
          state_next = axis_id_pkg::ST_FAULT;
        end
      end
      axis_id_pkg::ST_FAULT: begin
        // new error beats the clear
        if (fault_clear && !error_event) begin
          state_next = init_done ? axis_id_pkg::ST_RUN : axis_id_pkg::ST_WAIT_INIT;
        end
      end
      default: begin
        state_next = axis_id_pkg::ST_FAULT;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= axis_id_pkg::ST_WAIT_INIT;
      ready_reg <= 1'b0;
      fault_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      ready_reg <= state_next == axis_id_pkg::ST_RUN;
      fault_reg <= state_next == axis_id_pkg::ST_FAULT;
    end
  end

  // ==========================================================
  // green led flash
  assign flash_tick = flash_count_reg == FLASH_LAST;
  assign flash_count_next = (!lss_inactive_reg || flash_tick) ? '0 : flash_count_reg + 1'b1;
  assign green_led_next = !(lss_inactive_reg && control_reg[`CTL_LED_EN_BIT]) ? 1'b0 :
    (flash_tick ? ~green_led_reg : green_led_reg);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flash_count_reg <= '0;
      green_led_reg <= 1'b0;
    end else begin
      flash_count_reg <= flash_count_next;
      green_led_reg <= green_led_next;
    end
  end

  // ==========================================================
  // interrupts
  assign irq_events[`IRQ_ADDR_BIT] = sample_take;
  assign irq_events[`IRQ_ERROR_BIT] = error_event;
  assign irq_events[`IRQ_INIT_BIT] = state_reg == axis_id_pkg::ST_WAIT_INIT &&
    state_next == axis_id_pkg::ST_RUN;
  assign irq_events[`IRQ_LSS_BIT] = lss_enter;
  assign irq_clear = (do_write && wr_irq_status && wr_strb[0]) ? wr_data[`IRQ_WIDTH-1:0] : '0;
  // set wins over a same-cycle clear
  assign irq_status_next = (irq_status_reg & ~irq_clear) | irq_events;
  assign irq_mask_next = (do_write && wr_irq_mask) ?
    `IRQ_WIDTH'(lane_merge(32'(irq_mask_reg), wr_data, wr_strb)) : irq_mask_reg;
  assign control_next = (do_write && wr_control) ?
    3'(lane_merge(32'(control_reg), wr_data, wr_strb)) & 3'h5 : control_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_status_reg <= '0;
      irq_mask_reg <= '0;
      control_reg <= `CTL_RESET;
    end else begin
      irq_status_reg <= irq_status_next;
      irq_mask_reg <= irq_mask_next;
      control_reg <= control_next;
    end
  end

  // ==========================================================
  // axi4-lite write path
  assign aw_fire = s_axi_awvalid & awready_reg;
  assign w_fire = s_axi_wvalid & wready_reg;
  assign aw_have = aw_hold_reg | aw_fire;
  assign w_have = w_hold_reg | w_fire;
  assign do_write = aw_have & w_have & ~bvalid_reg;
  assign aw_hold_next = aw_have & ~do_write;
  assign w_hold_next = w_have & ~do_write;
  assign bvalid_next = do_write | (bvalid_reg & ~s_axi_bready);
  assign awready_next = ~aw_hold_next & ~bvalid_next;
  assign wready_next = ~w_hold_next & ~bvalid_next;
  assign wr_addr = word_addr(aw_fire ? s_axi_awaddr : awaddr_reg);
  assign wr_data = w_fire ? s_axi_wdata : wdata_reg;
  assign wr_strb = w_fire ? s_axi_wstrb : wstrb_reg;
  assign wr_control = wr_addr == 5'(`REG_CONTROL);
  assign wr_irq_status = wr_addr == 5'(`REG_IRQ_STATUS);
  assign wr_irq_mask = wr_addr == `REG_IRQ_MASK;
  assign wr_mapped = wr_control | wr_irq_status | wr_irq_mask;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_reg <= 1'b0;
      w_hold_reg <= 1'b0;
      awaddr_reg <= 5'h00;
      wdata_reg <= 32'h0;
      wstrb_reg <= 4'h0;
      awready_reg <= 1'b0;
      wready_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= `RESP_OKAY;
    end else begin
      aw_hold_reg <= aw_hold_next;
      w_hold_reg <= w_hold_next;
      if (aw_fire) begin
        awaddr_reg <= s_axi_awaddr;
      end
      if (w_fire) begin
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      awready_reg <= awready_next;
      wready_reg <= wready_next;
      bvalid_reg <= bvalid_next;
      if (do_write) begin
        bresp_reg <= wr_mapped ? `RESP_OKAY : `RESP_SLVERR;
      end
    end
  end

  // ==========================================================
  // axi4-lite read path
  assign ar_fire = s_axi_arvalid & arready_reg;
  assign rvalid_next = ar_fire | (rvalid_reg & ~s_axi_rready);
  assign arready_next = ~rvalid_next;
  assign rd_addr = word_addr(s_axi_araddr);
  assign status_word = {15'h0, raw_code_reg, 3'h0, addr_valid_reg, fault_reg,
    ready_reg, lss_inactive_reg, mode_reg};
  assign rd_mapped = rd_addr == 5'(`REG_ADDR_CODE) || rd_addr == 5'(`REG_STATUS) ||
    rd_addr == 5'(`REG_CONTROL) || rd_addr == 5'(`REG_IRQ_STATUS) || rd_addr == `REG_IRQ_MASK;
  assign rd_word = (rd_addr == 5'(`REG_ADDR_CODE)) ? {23'h0, axis_address_reg} :
    (rd_addr == 5'(`REG_STATUS)) ? status_word :
    (rd_addr == 5'(`REG_CONTROL)) ? {29'h0, control_reg} :
    (rd_addr == 5'(`REG_IRQ_STATUS)) ? {28'h0, irq_status_reg} :
    (rd_addr == `REG_IRQ_MASK) ? {28'h0, irq_mask_reg} : 32'h0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0;
      rresp_reg <= `RESP_OKAY;
    end else begin
      arready_reg <= arready_next;
      rvalid_reg <= rvalid_next;
      if (ar_fire) begin
        rdata_reg <= rd_word;
        rresp_reg <= rd_mapped ? `RESP_OKAY : `RESP_SLVERR;
      end
    end
  end

  // ==========================================================
  // interrupt output register
  logic irq_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(irq_status_next & irq_mask_next);
    end
  end

  // ==========================================================
  // outputs
  assign ready_indicator = ready_reg;
  assign fault_indicator = fault_reg;
  assign green_led = green_led_reg;
  assign vendor_can_protocol_mode = mode_reg;
  assign axis_address = axis_address_reg;
  assign irq = irq_reg;
  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;

endmodule

// *** pkg/axis_id_params.svh ***
// Purpose: named constants for the axis address strap decoder
// Assumes: strap voltages arrive as 12-bit millivolt codes
// Notes: offsets are byte addresses on the register bus
`ifndef AXIS_ID_PARAMS_SVH
`define AXIS_ID_PARAMS_SVH

// ==========================================================
// clock and timing
`define CLK_PERIOD_NS 100
`define LED_FLASH_MS 1000
`define NS_PER_MS 1000000

// ==========================================================
// quantizer band edges in millivolts
`define STRAP_EDGE_0 12'h212
`define STRAP_EDGE_1 12'h582
`define STRAP_EDGE_2 12'h7da
`define STRAP_EDGE_3 12'h97e
`define STRAP_EDGE_4 12'habe
`define STRAP_EDGE_5 12'hbc2
`define STRAP_EDGE_6 12'hc94

// ==========================================================
// address arithmetic
`define VENDOR_ADDR_OFFSET 9'h080
`define UNSTRAPPED_ADDR 9'h0ff
`define VENDOR_SEL_BIT 7

// ==========================================================
// register offsets
`define REG_ADDR_CODE 4'h0
`define REG_STATUS 4'h4
`define REG_CONTROL 4'h8
`define REG_IRQ_STATUS 4'hc
`define REG_IRQ_MASK 5'h10

// ==========================================================
// status fields
`define ST_VENDOR_BIT 0
`define ST_LSS_BIT 1
`define ST_READY_BIT 2
`define ST_FAULT_BIT 3
`define ST_VALID_BIT 4
`define ST_RAW_LSB 8

// ==========================================================
// control fields and reset value
`define CTL_DECODE_EN_BIT 0
`define CTL_FAULT_CLR_BIT 1
`define CTL_LED_EN_BIT 2
`define CTL_RESET 3'h5

// ==========================================================
// interrupt events
`define IRQ_WIDTH 4
`define IRQ_ADDR_BIT 0
`define IRQ_ERROR_BIT 1
`define IRQ_INIT_BIT 2
`define IRQ_LSS_BIT 3

// ==========================================================
// bus responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// *** pkg/axis_id_pkg.sv ***
// Purpose: shared types of the axis address strap decoder
// Assumes: nothing beyond the constants header
// Notes: states use gray codes along the usual path
package axis_id_pkg;

  // ==========================================================
  // drive readiness
  typedef enum logic [1:0] {
    ST_WAIT_INIT = 2'h0,
    ST_RUN = 2'h1,
    ST_FAULT = 2'h3
  } drive_state_type;

  // ==========================================================
  // protocol selected by the straps
  typedef enum logic {
    MODE_CANOPEN = 1'h0,
    MODE_VENDOR = 1'h1
  } can_mode_type;

endpackage

// *** hw/strap_quantizer.sv ***
// Purpose: turn one strap voltage into a 3-bit band code
// Assumes: voltage is a 12-bit millivolt value
// Notes: a value on an edge belongs to the higher band
`timescale 1ns/100ps
`include "axis_id_params.svh"

module strap_quantizer (
  // strap voltage
  input wire logic [11:0] millivolts,
  // band code
  output logic [2:0] strap_value
);

  logic [6:0] above;

  // ==========================================================
  // compare against every band edge
  assign above[0] = millivolts >= `STRAP_EDGE_0;
  assign above[1] = millivolts >= `STRAP_EDGE_1;
  assign above[2] = millivolts >= `STRAP_EDGE_2;
  assign above[3] = millivolts >= `STRAP_EDGE_3;
  assign above[4] = millivolts >= `STRAP_EDGE_4;
  assign above[5] = millivolts >= `STRAP_EDGE_5;
  assign above[6] = millivolts >= `STRAP_EDGE_6;

  // edges rise monotonically, so the count is the band
  assign strap_value = 3'(above[0]) + 3'(above[1]) + 3'(above[2]) + 3'(above[3])
    + 3'(above[4]) + 3'(above[5]) + 3'(above[6]);

endmodule

// *** dv/axis_id_strap_decode_chk.sv ***
// Purpose: port-level checks of the strap decoder
// Assumes: one clock, sync active-low reset
// Notes: bound from the testbench top
`timescale 1ns/100ps
`include "axis_id_params.svh"

module axis_id_strap_decode_chk #(
  parameter int FLASH_CYCLES = 8
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // straps and events
  input wire logic [11:0] strap_low_mv,
  input wire logic [11:0] strap_mid_mv,
  input wire logic [11:0] strap_high_mv,
  input wire logic strap_sample,
  input wire logic init_done,
  input wire logic error_event,
  // indicators
  input wire logic ready_indicator,
  input wire logic fault_indicator,
  input wire logic green_led,
  input wire logic vendor_can_protocol_mode,
  input wire logic [8:0] axis_address,
  // write channels
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // ==========================================================
  // expected decode
  function automatic logic [2:0] band(input logic [11:0] mv);
    band = 3'h0;
    if (mv >= `STRAP_EDGE_0) band = 3'h1;
    if (mv >= `STRAP_EDGE_1) band = 3'h2;
    if (mv >= `STRAP_EDGE_2) band = 3'h3;
    if (mv >= `STRAP_EDGE_3) band = 3'h4;
    if (mv >= `STRAP_EDGE_4) band = 3'h5;
    if (mv >= `STRAP_EDGE_5) band = 3'h6;
    if (mv >= `STRAP_EDGE_6) band = 3'h7;
  endfunction

  wire [8:0] code = {band(strap_high_mv), band(strap_mid_mv), band(strap_low_mv)};
  wire [8:0] exp_addr = (code == 9'h000) ? 9'h0ff : (code[7] ? code - 9'h080 : code);
  wire exp_vendor = code[7];

  // cycles since the led last changed
  logic led_q;
  int unsigned led_cnt;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      led_q <= 1'b0;
      led_cnt <= 0;
    end else begin
      led_q <= green_led;
      led_cnt <= (green_led != led_q) ? 0 : led_cnt + 1;
    end
  end

  // ==========================================================
  // properties
  property p_ready_after_init;
    $rose(ready_indicator) |-> $past(init_done);
  endproperty
  a_ready_after_init: assert property (p_ready_after_init) else $error("ready without init");

  property p_err_drops_ready;
    error_event |=> !ready_indicator;
  endproperty
  a_err_drops_ready: assert property (p_err_drops_ready) else $error("ready kept on error");

  property p_err_sets_fault;
    error_event |=> fault_indicator;
  endproperty
  a_err_sets_fault: assert property (p_err_sets_fault) else $error("fault not raised");

  property p_fault_excl;
    fault_indicator |-> !ready_indicator;
  endproperty
  a_fault_excl: assert property (p_fault_excl) else $error("ready during fault");

  property p_decode;
    strap_sample |=> (axis_address == $past(exp_addr) && vendor_can_protocol_mode == $past(exp_vendor))
      || (axis_address == $past(axis_address) && vendor_can_protocol_mode == $past(vendor_can_protocol_mode));
  endproperty
  a_decode: assert property (p_decode) else $error("wrong decode");

  property p_flash;
    (led_q && !green_led && !$past(strap_sample) && !$past(strap_sample, 2) && !$past(s_axi_wvalid)
      && !$past(s_axi_wvalid, 2)) |-> led_cnt == FLASH_CYCLES - 1;
  endproperty
  a_flash: assert property (p_flash) else $error("led period wrong");

  property p_bvalid_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_bvalid_hold: assert property (p_bvalid_hold) else $error("write response dropped");

  property p_write_answer;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid && !s_axi_awready;
  endproperty
  a_write_answer: assert property (p_write_answer) else $error("write not answered");

  c_vendor: cover property (strap_sample ##1 vendor_can_protocol_mode);
  c_flash: cover property ($rose(green_led));
  c_fault: cover property ($rose(fault_indicator));
endmodule

// *** dv/strap_board_model.sv ***
// Purpose: board strap dividers and green led observer
// Assumes: divider voltages given in millivolts
// Notes: at_edge puts codes 1 to 7 on their band's lower edge
`timescale 1ns/100ps
`include "axis_id_params.svh"

module strap_board_model (
  // clock
  input wire logic aclk,
  // chosen strap codes
  input wire logic [2:0] high_code,
  input wire logic [2:0] mid_code,
  input wire logic [2:0] low_code,
  input wire logic at_edge,
  // divider voltages
  output logic [11:0] high_mv,
  output logic [11:0] mid_mv,
  output logic [11:0] low_mv,
  // led observation
  input wire logic green_led,
  output int led_period
);
  // code 0 at edge sits just under the first edge
  function automatic logic [11:0] volts(input logic [2:0] c, input logic e);
    logic [11:0] nom [8] = '{12'h000, 12'h424, 12'h6e0, 12'h8ca, 12'ha28, 12'hb4a, 12'hc3a, 12'hcf8};
    logic [11:0] low [8] = '{`STRAP_EDGE_0 - 12'h001, `STRAP_EDGE_0, `STRAP_EDGE_1, `STRAP_EDGE_2,
      `STRAP_EDGE_3, `STRAP_EDGE_4, `STRAP_EDGE_5, `STRAP_EDGE_6};
    volts = e ? low[c] : nom[c];
  endfunction

  assign high_mv = volts(high_code, at_edge);
  assign mid_mv = volts(mid_code, at_edge);
  assign low_mv = volts(low_code, at_edge);

  logic led_q = 1'b0;
  int cnt = 0;
  initial led_period = 0;
  always @(posedge aclk) begin
    led_q <= green_led;
    if (green_led != led_q) begin
      led_period <= cnt;
      cnt <= 1;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule

// *** dv/axis_id_strap_decode_test.sv ***
// Purpose: self-checking bench of the strap decoder
// Assumes: short flash count, straps from the board model
// Notes: init readiness first, then table rows, fault, irq and bus cases
`timescale 1ns/100ps

module axis_id_strap_decode_test;
  localparam int FLASH = 8;
  typedef struct {logic [2:0] h; logic [2:0] m; logic [2:0] l; logic e; logic [8:0] addr; logic vend;} row_type;
  row_type rows [10] = '{'{0, 0, 1, 0, 9'h001, 0}, '{0, 0, 0, 1, 9'h0ff, 0}, '{1, 2, 3, 1, 9'h053, 0},
    '{2, 0, 0, 0, 9'h000, 1}, '{3, 7, 7, 0, 9'h07f, 1}, '{4, 5, 6, 1, 9'h12e, 0}, '{5, 5, 5, 0, 9'h16d, 0},
    '{6, 0, 0, 0, 9'h100, 1}, '{7, 7, 7, 1, 9'h17f, 1}, '{0, 0, 0, 0, 9'h0ff, 0}};
  logic aclk = 1'b0, aresetn = 1'b0, strap_sample = 1'b0, init_done = 1'b0, error_event = 1'b0, at_edge = 1'b0;
  logic [2:0] high_code = 3'h0, mid_code = 3'h0, low_code = 3'h0;
  logic [11:0] strap_low_mv, strap_mid_mv, strap_high_mv;
  logic ready_indicator, fault_indicator, green_led, vendor_can_protocol_mode, irq;
  logic [8:0] axis_address;
  logic [4:0] s_axi_awaddr = 5'h00, s_axi_araddr = 5'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  int led_period, err_count = 0, compares = 0, cycles = 0;

  axis_id_strap_decode #(.FLASH_CYCLES(FLASH)) dut_u (.*, .s_axi_wstrb(4'hf));

  strap_board_model board_u (.aclk(aclk), .high_code(high_code), .mid_code(mid_code), .low_code(low_code),
    .at_edge(at_edge), .high_mv(strap_high_mv), .mid_mv(strap_mid_mv), .low_mv(strap_low_mv),
    .green_led(green_led), .led_period(led_period));

  // ==========================================================
  // clock, timeout, helpers
  initial begin
    forever #50 aclk = ~aclk;
  end

  always @(posedge aclk) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    $display("compares %0d, mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input logic ok, input string what);
    compares++;
    if (ok !== 1'b1) begin
      err_count++;
      $display("[ERR] %0t %s", $time, what);
    end
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge aclk);
    @(negedge aclk);
  endtask

  task automatic pulse(input logic err);
    @(posedge aclk);
    if (err) error_event <= 1'b1;
    else strap_sample <= 1'b1;
    @(posedge aclk);
    error_event <= 1'b0;
    strap_sample <= 1'b0;
    @(negedge aclk);
  endtask

  task automatic axi_write(input logic [4:0] a, input logic [31:0] d, output logic [1:0] r);
    int n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && n < 50);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic axi_read(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
    int n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && n < 50);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  // ==========================================================
  // main sequence
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    settle(5);
    chk(ready_indicator === 1'b0 && fault_indicator === 1'b0, "ready before init");
    axi_read(5'h08, rd, rs);
    chk(rd === 32'h5 && rs === 2'h0, "control reset value");
    axi_write(5'h10, 32'hf, rs);
    @(posedge aclk);
    init_done <= 1'b1;
    settle(2);
    chk(ready_indicator === 1'b1 && irq === 1'b1, "ready after init");
    for (int i = 0; i < 10; i++) begin
      @(posedge aclk);
      {high_code, mid_code, low_code, at_edge} <= {rows[i].h, rows[i].m, rows[i].l, rows[i].e};
      pulse(1'b0);
      chk(axis_address === rows[i].addr && vendor_can_protocol_mode === rows[i].vend, "decode");
      axi_read(5'h00, rd, rs);
      chk(rd === {23'h0, rows[i].addr} && rs === 2'h0, "address register");
    end
    settle(40);
    chk(led_period === FLASH, "led flash period");
    axi_read(5'h04, rd, rs);
    chk(rd[1] === 1'b1 && rd[0] === 1'b0, "lss inactive status");
    axi_write(5'h08, 32'h4, rs);
    @(posedge aclk);
    {high_code, mid_code, low_code} <= 9'h049;
    pulse(1'b0);
    chk(axis_address === 9'h0ff, "sample while decode off");
    axi_write(5'h08, 32'h5, rs);
    pulse(1'b1);
    chk(ready_indicator === 1'b0 && fault_indicator === 1'b1, "error response");
    axi_write(5'h08, 32'h7, rs);
    settle(1);
    chk(ready_indicator === 1'b1 && fault_indicator === 1'b0, "fault cleared");
    axi_write(5'h0c, 32'hf, rs);
    settle(2);
    chk(irq === 1'b0, "irq cleared");
    axi_write(5'h10, 32'h0, rs);
    pulse(1'b1);
    settle(2);
    chk(irq === 1'b0 && fault_indicator === 1'b1, "masked error");
    axi_write(5'h10, 32'h2, rs);
    settle(2);
    chk(irq === 1'b1, "unmasked error");
    axi_write(5'h0c, 32'h2, rs);
    settle(2);
    chk(irq === 1'b0, "error irq cleared");
    axi_write(5'h14, 32'h1, rs);
    chk(rs === 2'h2, "unmapped write");
    axi_read(5'h14, rd, rs);
    chk(rd === 32'h0 && rs === 2'h2, "unmapped read");
    tally_and_finish();
  end
endmodule

bind axis_id_strap_decode axis_id_strap_decode_chk #(.FLASH_CYCLES(FLASH_CYCLES)) chk_u (.*);
